// >>> core/thermal_defs.svh
// constants for the thermal assist sample control block
// Functional notes
// - compare only when enabled and a threshold valid
// - wait interval cycles, then sample comparator result
// - thresholds and control at numbers 1020-1022
// - read-only signed calibration offset at 920
// - calibration upper bits always read zero
// - alternate thresholds in time when both active
// - seven-bit threshold field compared with sensor
// - direction bit picks above or below crossing
// - irq enable gates interrupt, flag still records
`ifndef THERMAL_DEFS_SVH
`define THERMAL_DEFS_SVH

//------------------------------------------------------------
// special register numbers
//------------------------------------------------------------
`define SPR_THR_A         10'h3fc
`define SPR_THR_B         10'h3fd
`define SPR_CTRL          10'h3fe
`define SPR_CALIB         10'h398

//------------------------------------------------------------
// threshold register fields (bit 0 is the lsb)
//------------------------------------------------------------
`define THR_TIN_BIT       31
`define THR_TIV_BIT       30
`define THR_VAL_MSB       29
`define THR_VAL_LSB       23
`define THR_DIR_BIT       2
`define THR_IE_BIT        1
`define THR_V_BIT         0
`define THR_WR_MASK       32'h3f800007
`define THR_RESET         32'h00000000

//------------------------------------------------------------
// sample control register fields
//------------------------------------------------------------
`define CTRL_SAMPLE_INTERVAL_COUNT_MSB     16
`define CTRL_SAMPLE_INTERVAL_COUNT_LSB     1
`define CTRL_EN_BIT       0
`define CTRL_WR_MASK      32'h0001ffff
`define CTRL_RESET        32'h00000000

//------------------------------------------------------------
// calibration offset field
//------------------------------------------------------------
`define CALIB_MSB         7
`define CALIB_RESET       8'h00

//------------------------------------------------------------
// advised sampling interval, for software reference
//------------------------------------------------------------
`define SAMPLE_TIME_US    20
`define CLK_FREQ_MHZ      40
`define SAMPLE_TIME_CYC   (`SAMPLE_TIME_US * `CLK_FREQ_MHZ)

`endif

// >>> core/thermal_pkg.sv
// types shared by the thermal assist sample control block
package thermal_pkg;
	typedef logic [9:0]  spr_num_t;
	typedef logic [31:0] word_t;
	typedef logic [15:0] interval_t;
	typedef logic [6:0]  thresh_t;
	typedef logic [7:0]  calib_t;
	// which threshold the comparator currently faces
	typedef enum logic [1:0] {
		SEL_A = 2'b01,
		SEL_B = 2'b10
	} sel_t;
endpackage

// >>> core/sample_interval_timer.sv
// sample interval timer: one sample pulse per programmed interval
`include "thermal_defs.svh"
module sample_interval_timer (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  srst,
	// control
	input  wire logic                  run,
	input  wire thermal_pkg::interval_t interval,
	// sample strobe
	output logic                       sample
);
	import thermal_pkg::*;

	interval_t cnt_reg;
	interval_t cnt_next;
	logic      sample_reg;
	logic      sample_next;

	// count down while running, reload after each sample or when stopped
	always_comb begin
		cnt_next    = cnt_reg;
		sample_next = 1'b0;
		if (!run) begin
			cnt_next = interval;
		end else if (cnt_reg <= 16'h0001) begin
			cnt_next    = interval;
			sample_next = 1'b1;
		end else begin
			cnt_next = cnt_reg - 16'h0001;
		end
	end

	// register the timer state
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt_reg    <= 16'h0000;
			sample_reg <= 1'b0;
		end else begin
			cnt_reg    <= cnt_next;
			sample_reg <= sample_next;
		end
	end

	assign sample = sample_reg;

	// last count gives a sample on the next edge
	chk_count_to_sample: assert property (@(posedge ref_clk) disable iff (srst)
		(run && cnt_reg == 16'h0001) |=> sample_reg)
		else $error("sample missing after final count");

	// stopped timer holds the reloaded value and gives no sample
	chk_hold_reload: assert property (@(posedge ref_clk) disable iff (srst)
		!run |=> (cnt_reg == $past(interval)) && !sample_reg)
		else $error("timer not held at reload while stopped");

	// after a sample the counter starts again from the interval
	chk_reload_after: assert property (@(posedge ref_clk) disable iff (srst)
		(run && cnt_reg == 16'h0003 && interval == 16'h0003)
		##1 (run && interval == 16'h0003) [*2] |=> sample_reg)
		else $error("interval of three not honoured");
endmodule

// >>> core/thermal_assist_sample_control.sv
// thermal assist sample control: threshold, control and offset registers
`include "thermal_defs.svh"
module thermal_assist_sample_control (
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	// special register move port
	input  wire thermal_pkg::spr_num_t spr_num,
	input  wire logic                 spr_wr_en,
	input  wire thermal_pkg::word_t   spr_wr_data,
	input  wire logic                 spr_rd_en,
	output thermal_pkg::word_t        spr_rd_data,
	output logic                      spr_rd_ack,
	output logic                      spr_rd_hit,
	// analog sensor side
	input  wire logic                 cmp_above_pin,
	input  wire thermal_pkg::calib_t  calib_fuse_pin,
	output logic                      cmp_enable,
	output thermal_pkg::thresh_t      cmp_threshold,
	// thermal interrupt
	output logic                      thermal_irq
);
	import thermal_pkg::*;

	localparam spr_num_t THR_SPR [2] = '{`SPR_THR_A, `SPR_THR_B};

	//------------------------------------------------------------
	// declarations
	//------------------------------------------------------------
	logic      above_s1_reg;
	logic      above_s2_reg;
	calib_t    fuse_s1_reg;
	calib_t    fuse_s2_reg;
	calib_t    calib_reg;
	word_t     ctrl_reg;
	word_t     ctrl_next;
	word_t     thr_reg [2];
	word_t     thr_next [2];
	sel_t      sel_reg;
	sel_t      sel_next;
	logic      active;
	logic      sample_pulse;
	logic      sel_idx;
	logic      both_valid;
	logic [1:0] thr_valid;
	logic [1:0] smp_hit;
	logic [1:0] wr_hit;
	logic [1:0] irq_src;
	logic      irq_reg;
	logic      irq_next;
	logic      cmp_en_reg;
	logic      cmp_en_next;
	thresh_t   cmp_thr_reg;
	thresh_t   cmp_thr_next;
	word_t     rd_data_reg;
	word_t     rd_data_next;
	logic      rd_ack_reg;
	logic      rd_hit_reg;
	logic      rd_hit_next;

	//------------------------------------------------------------
	// input synchronisers
	//------------------------------------------------------------
	// comparator level crosses in through two flops, fuse word through three
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			above_s1_reg <= 1'b0;
			above_s2_reg <= 1'b0;
			fuse_s1_reg  <= `CALIB_RESET;
			fuse_s2_reg  <= `CALIB_RESET;
			calib_reg    <= `CALIB_RESET;
		end else begin
			above_s1_reg <= cmp_above_pin;
			above_s2_reg <= above_s1_reg;
			fuse_s1_reg  <= calib_fuse_pin;
			fuse_s2_reg  <= fuse_s1_reg;
			calib_reg    <= fuse_s2_reg;
		end
	end

	//------------------------------------------------------------
	// sample control register
	//------------------------------------------------------------
	// reserved bits are dropped on write and read as zero
	always_comb begin
		ctrl_next = ctrl_reg;
		if (spr_wr_en && spr_num == `SPR_CTRL) begin
			ctrl_next = spr_wr_data & `CTRL_WR_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_reg <= `CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// compare runs only when enabled with a valid threshold
	assign active     = ctrl_reg[`CTRL_EN_BIT] & (|thr_valid);
	assign both_valid = &thr_valid;
	assign sel_idx    = (sel_reg == SEL_B);

	//------------------------------------------------------------
	// sample interval timer
	//------------------------------------------------------------
	// the held count follows the next control value, so an enabling write
	// starts the timer from the interval it writes, not the one before
	sample_interval_timer u_timer (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.run      (active),
		.interval (ctrl_next[`CTRL_SAMPLE_INTERVAL_COUNT_MSB:`CTRL_SAMPLE_INTERVAL_COUNT_LSB]),
		.sample   (sample_pulse)
	);

	//------------------------------------------------------------
	// threshold registers, one per channel
	//------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_thr
			assign thr_valid[gi] = thr_reg[gi][`THR_V_BIT];
			assign wr_hit[gi]    = spr_wr_en && (spr_num == THR_SPR[gi]);
			assign smp_hit[gi]   = sample_pulse && active && thr_valid[gi]
				&& (sel_idx == 1'(gi));
			assign irq_src[gi]   = thr_valid[gi] && thr_reg[gi][`THR_TIV_BIT]
				&& thr_reg[gi][`THR_TIN_BIT] && thr_reg[gi][`THR_IE_BIT];

			// a write clears the status; a sample in the same cycle wins
			always_comb begin
				thr_next[gi] = thr_reg[gi];
				if (wr_hit[gi]) begin
					thr_next[gi] = spr_wr_data & `THR_WR_MASK;
				end
				if (smp_hit[gi]) begin
					thr_next[gi][`THR_TIV_BIT] = 1'b1;
					thr_next[gi][`THR_TIN_BIT] = thr_reg[gi][`THR_DIR_BIT] ?
						~above_s2_reg : above_s2_reg;
				end
			end

			always_ff @(posedge ref_clk) begin
				if (srst) begin
					thr_reg[gi] <= `THR_RESET;
				end else begin
					thr_reg[gi] <= thr_next[gi];
				end
			end
		end
	endgenerate

	//------------------------------------------------------------
	// channel selection and sensor drive
	//------------------------------------------------------------
	// alternate after each sample when both thresholds are valid
	always_comb begin
		sel_next = sel_reg;
		case (sel_reg)
			SEL_A: begin
				if (!thr_valid[0] || (both_valid && sample_pulse && active)) begin
					sel_next = thr_valid[1] ? SEL_B : SEL_A;
				end
			end
			SEL_B: begin
				if (!thr_valid[1] || (both_valid && sample_pulse && active)) begin
					sel_next = thr_valid[0] ? SEL_A : SEL_B;
				end
			end
			default: begin
				sel_next = SEL_A;
			end
		endcase
		cmp_en_next  = active;
		cmp_thr_next = thr_reg[sel_idx][`THR_VAL_MSB:`THR_VAL_LSB];
		irq_next     = |irq_src;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sel_reg     <= SEL_A;
			cmp_en_reg  <= 1'b0;
			cmp_thr_reg <= 7'h00;
			irq_reg     <= 1'b0;
		end else begin
			sel_reg     <= sel_next;
			cmp_en_reg  <= cmp_en_next;
			cmp_thr_reg <= cmp_thr_next;
			irq_reg     <= irq_next;
		end
	end

	//------------------------------------------------------------
	// register read port
	//------------------------------------------------------------
	// answer one cycle after the read strobe, zero when unmapped
	always_comb begin
		rd_data_next = 32'h00000000;
		rd_hit_next  = 1'b0;
		if (spr_rd_en) begin
			case (spr_num)
				`SPR_THR_A: begin
					rd_data_next = thr_reg[0];
					rd_hit_next  = 1'b1;
				end
				`SPR_THR_B: begin
					rd_data_next = thr_reg[1];
					rd_hit_next  = 1'b1;
				end
				`SPR_CTRL: begin
					rd_data_next = ctrl_reg;
					rd_hit_next  = 1'b1;
				end
				`SPR_CALIB: begin
					rd_data_next = {24'h000000, calib_reg};
					rd_hit_next  = 1'b1;
				end
				default: begin
					rd_data_next = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rd_data_reg <= 32'h00000000;
			rd_ack_reg  <= 1'b0;
			rd_hit_reg  <= 1'b0;
		end else begin
			rd_data_reg <= rd_data_next;
			rd_ack_reg  <= spr_rd_en;
			rd_hit_reg  <= rd_hit_next;
		end
	end

	assign spr_rd_data   = rd_data_reg;
	assign spr_rd_ack    = rd_ack_reg;
	assign spr_rd_hit    = rd_hit_reg;
	assign cmp_enable    = cmp_en_reg;
	assign cmp_threshold = cmp_thr_reg;
	assign thermal_irq   = irq_reg;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	sequence calib_read_s;
		spr_rd_en && spr_num == `SPR_CALIB;
	endsequence

	sequence both_sampled_s;
		sample_pulse && active && both_valid && !wr_hit[0] && !wr_hit[1];
	endsequence

	chk_no_idle_status: assert property (@(posedge ref_clk) disable iff (srst)
		!active |=> $stable(thr_reg[0][`THR_TIV_BIT]) || $past(wr_hit[0]))
		else $error("status changed while compare disabled");

	chk_flag_direction: assert property (@(posedge ref_clk) disable iff (srst)
		smp_hit[0] |=> thr_reg[0][`THR_TIV_BIT] && (thr_reg[0][`THR_TIN_BIT] ==
		($past(thr_reg[0][`THR_DIR_BIT]) ^ $past(above_s2_reg))))
		else $error("crossed flag wrong after sample");

	chk_calib_upper: assert property (@(posedge ref_clk) disable iff (srst)
		calib_read_s |=> spr_rd_hit && spr_rd_data[31:8] == 24'h000000)
		else $error("offset upper bits not zero");

	chk_calib_value: assert property (@(posedge ref_clk) disable iff (srst)
		calib_read_s |=> spr_rd_data[`CALIB_MSB:0] == $past(calib_reg))
		else $error("offset read mismatch");

	chk_ctrl_readback: assert property (@(posedge ref_clk) disable iff (srst)
		(spr_wr_en && spr_num == `SPR_CTRL) ##1 (spr_rd_en && spr_num == `SPR_CTRL)
		|=> spr_rd_data == ($past(spr_wr_data, 2) & `CTRL_WR_MASK))
		else $error("control readback mismatch");

	chk_alternate_sel: assert property (@(posedge ref_clk) disable iff (srst)
		both_sampled_s |=> sel_reg != $past(sel_reg))
		else $error("dual thresholds did not alternate");

	chk_irq_gate: assert property (@(posedge ref_clk) disable iff (srst)
		(!thr_reg[0][`THR_IE_BIT] && !thr_reg[1][`THR_IE_BIT]) |=> !thermal_irq)
		else $error("interrupt raised with enables clear");

	chk_threshold_out: assert property (@(posedge ref_clk) disable iff (srst)
		active ##1 active |-> cmp_enable
		&& cmp_threshold == $past(thr_reg[sel_idx][`THR_VAL_MSB:`THR_VAL_LSB]))
		else $error("comparator threshold not driven");
endmodule

// >>> dv/thermal_sensor_model.sv
// behavioural model of the analog sensor, converter and comparator
module thermal_sensor_model #(
	parameter thermal_pkg::calib_t fuse_value = 8'h00
) (
	// clock
	input  wire logic                 ref_clk,
	// from the block
	input  wire logic                 cmp_enable,
	input  wire thermal_pkg::thresh_t cmp_threshold,
	// junction temperature in degrees
	input  wire logic [7:0]           temp_c,
	// toward the block
	output logic                      cmp_above_pin,
	output thermal_pkg::calib_t       calib_fuse_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	import thermal_pkg::*;

	logic toggle_reg = 1'b0;

	// idle comparator output wanders, so a stale level is never seen
	always @(posedge ref_clk) begin
		toggle_reg <= ~toggle_reg;
	end

	// above when the junction exceeds the dac level of the threshold
	assign cmp_above_pin = cmp_enable ? (temp_c > {1'b0, cmp_threshold}) : toggle_reg;
	// factory offset is static
	assign calib_fuse_pin = fuse_value;
endmodule

// >>> dv/thermal_assist_sample_control_tb.sv
// self-checking bench for the thermal assist sample control block
`include "thermal_defs.svh"
module thermal_assist_sample_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import thermal_pkg::*;

	typedef struct {spr_num_t num; word_t wd; word_t rd; logic hit;} row_t;
	localparam calib_t fuse_val = 8'hfd; // offset of -3 degrees
	localparam thresh_t thr_b = 7'h46;

	logic       ref_clk;
	logic       srst;
	spr_num_t   spr_num;
	logic       spr_wr_en;
	word_t      spr_wr_data;
	logic       spr_rd_en;
	word_t      spr_rd_data;
	logic       spr_rd_ack;
	logic       spr_rd_hit;
	logic       cmp_above_pin;
	calib_t     calib_fuse_pin;
	logic       cmp_enable;
	thresh_t    cmp_threshold;
	logic       thermal_irq;
	logic [7:0] temp_c;
	int         error_cnt = 0;
	int         compares = 0;
	int         cnt;
	word_t      d;
	logic       h;
	logic       sa;
	logic       sb;
	thresh_t    thr;

	// write then read back; reserved and read-only bits masked
	row_t rows [8] = '{
		'{`SPR_THR_A, 32'hffffffff, 32'h3f800007, 1'b1},
		'{`SPR_THR_B, 32'h12345678, 32'h12000000, 1'b1},
		'{`SPR_CTRL, 32'h0001fffe, 32'h0001fffe, 1'b1}, // reserved bits zero
		'{`SPR_CALIB, 32'hffffffff, {24'h0, fuse_val}, 1'b1},
		'{10'h3ff, 32'hffffffff, 32'h00000000, 1'b0},
		'{`SPR_THR_A, 32'h00000000, 32'h00000000, 1'b1},
		'{`SPR_THR_B, 32'h00000000, 32'h00000000, 1'b1},
		'{`SPR_CTRL, 32'h00000000, 32'h00000000, 1'b1}
	};

	thermal_assist_sample_control uut (
		.ref_clk        (ref_clk),
		.srst           (srst),
		.spr_num        (spr_num),
		.spr_wr_en      (spr_wr_en),
		.spr_wr_data    (spr_wr_data),
		.spr_rd_en      (spr_rd_en),
		.spr_rd_data    (spr_rd_data),
		.spr_rd_ack     (spr_rd_ack),
		.spr_rd_hit     (spr_rd_hit),
		.cmp_above_pin  (cmp_above_pin),
		.calib_fuse_pin (calib_fuse_pin),
		.cmp_enable     (cmp_enable),
		.cmp_threshold  (cmp_threshold),
		.thermal_irq    (thermal_irq)
	);

	thermal_sensor_model #(.fuse_value(fuse_val)) sensor (
		.ref_clk        (ref_clk),
		.cmp_enable     (cmp_enable),
		.cmp_threshold  (cmp_threshold),
		.temp_c         (temp_c),
		.cmp_above_pin  (cmp_above_pin),
		.calib_fuse_pin (calib_fuse_pin)
	);

	// 40 mhz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	function automatic word_t mk_thr(input thresh_t t, input logic [2:0] f);
		return {2'b00, t, 20'h0, f};
	endfunction

	task automatic check(input word_t seen, input word_t exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic chk_bit(input logic seen, input logic exp);
		check({31'h0, seen}, {31'h0, exp});
	endtask

	task automatic spr_write(input spr_num_t n, input word_t v);
		@(posedge ref_clk);
		spr_num <= n;
		spr_wr_data <= v;
		spr_wr_en <= 1'b1;
		@(posedge ref_clk);
		spr_wr_en <= 1'b0;
	endtask

	// read answers one cycle after the strobe
	task automatic spr_read(input spr_num_t n, output word_t v, output logic hit);
		@(posedge ref_clk);
		spr_num <= n;
		spr_rd_en <= 1'b1;
		@(posedge ref_clk);
		spr_rd_en <= 1'b0;
		#1;
		chk_bit(spr_rd_ack, 1'b1);
		v = spr_rd_data;
		hit = spr_rd_hit;
	endtask

	task automatic read_check(input spr_num_t n, input word_t exp);
		word_t v;
		logic hit;
		spr_read(n, v, hit);
		check(v, exp);
	endtask

	// enable sampling and count cycles until the interrupt shows
	task automatic irq_delay(input word_t ctrl, output int c);
		spr_write(`SPR_CTRL, ctrl);
		c = 0;
		while (thermal_irq !== 1'b1 && c < 200) begin
			@(posedge ref_clk);
			#1;
			c++;
		end
	endtask

	// one channel a run: flags, temperature, expected status bits
	task automatic run_a(input logic [2:0] f, input logic [7:0] t, input word_t st);
		spr_write(`SPR_CTRL, 32'h0);
		spr_write(`SPR_THR_A, mk_thr(thr, f));
		temp_c = t;
		spr_write(`SPR_CTRL, 32'h7); // reserved bits zero
		repeat (15) @(posedge ref_clk);
		#1;
		chk_bit(thermal_irq, f[1] & st[31]);
		read_check(`SPR_THR_A, mk_thr(thr, f) | st);
	endtask

	task automatic finish_test;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		finish_test();
	end

	initial begin
		srst = 1'b1;
		spr_num = 10'h000;
		spr_wr_en = 1'b0;
		spr_wr_data = 32'h00000000;
		spr_rd_en = 1'b0;
		temp_c = 8'h3c;
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		read_check(`SPR_THR_A, 32'h0);
		read_check(`SPR_THR_B, 32'h0);
		read_check(`SPR_CTRL, 32'h0);
		chk_bit(thermal_irq, 1'b0);
		chk_bit(cmp_enable, 1'b0);
		$display("test reset done");
		foreach (rows[i]) begin
			spr_write(rows[i].num, rows[i].wd);
			spr_read(rows[i].num, d, h);
			check(d, rows[i].rd);
			chk_bit(h, rows[i].hit);
		end
		// write then read in the very next cycle returns the new value
		@(posedge ref_clk);
		spr_num <= `SPR_CTRL;
		spr_wr_data <= 32'h00000008;
		spr_wr_en <= 1'b1;
		@(posedge ref_clk);
		spr_wr_en <= 1'b0;
		spr_rd_en <= 1'b1;
		@(posedge ref_clk);
		spr_rd_en <= 1'b0;
		#1;
		check(spr_rd_data, 32'h00000008);
		$display("test register table done");
		// wanted 47 degrees, offset taken off first
		thr = 7'(8'd47 - fuse_val);
		// interval shortened from the advised 800 cycles for run time
		spr_write(`SPR_THR_A, mk_thr(thr, 3'b011));
		irq_delay(32'h7, cnt);
		check(cnt, 5);
		chk_bit(cmp_enable, 1'b1);
		check({25'h0, cmp_threshold}, {25'h0, thr});
		spr_read(`SPR_THR_A, d, h);
		check(d, mk_thr(thr, 3'b011) | 32'hc0000000);
		check(32'(d[29:23]) + 32'($signed(fuse_val)), 32'd47);
		spr_write(`SPR_CTRL, 32'h14);
		repeat (20) @(posedge ref_clk);
		spr_write(`SPR_THR_A, mk_thr(thr, 3'b011));
		@(posedge ref_clk);
		#1;
		chk_bit(thermal_irq, 1'b0);
		irq_delay(32'h15, cnt);
		check(cnt, 12);
		$display("test interval done");
		run_a(3'b001, 8'h3c, 32'hc0000000);
		run_a(3'b101, 8'h3c, 32'h40000000);
		run_a(3'b111, 8'h28, 32'hc0000000);
		$display("test direction and enable done");
		spr_write(`SPR_CTRL, 32'h0);
		spr_write(`SPR_THR_A, mk_thr(thr, 3'b001));
		spr_write(`SPR_THR_B, mk_thr(thr_b, 3'b001));
		temp_c = 8'h3c;
		// interval of four lets the comparator settle after each switch
		spr_write(`SPR_CTRL, 32'h9);
		sa = 1'b0;
		sb = 1'b0;
		repeat (40) begin
			@(posedge ref_clk);
			#1;
			sa = sa | (cmp_threshold === thr);
			sb = sb | (cmp_threshold === thr_b);
		end
		chk_bit(sa & sb, 1'b1);
		read_check(`SPR_THR_A, mk_thr(thr, 3'b001) | 32'hc0000000);
		read_check(`SPR_THR_B, mk_thr(thr_b, 3'b001) | 32'h40000000);
		$display("test dual threshold done");
		spr_write(`SPR_CTRL, 32'h6);
		spr_write(`SPR_THR_A, mk_thr(thr, 3'b011));
		repeat (15) @(posedge ref_clk);
		#1;
		chk_bit(cmp_enable, 1'b0);
		read_check(`SPR_THR_A, mk_thr(thr, 3'b011));
		spr_write(`SPR_THR_A, 32'h0);
		spr_write(`SPR_THR_B, 32'h0);
		spr_write(`SPR_CTRL, 32'h7);
		repeat (15) @(posedge ref_clk);
		#1;
		chk_bit(cmp_enable, 1'b0);
		chk_bit(thermal_irq, 1'b0);
		$display("test disabled compare done");
		finish_test();
	end
endmodule
